// [rtl/gpf_defs.svh]
// Purpose: Offsets, field positions, reset values for the pin interrupt flag bank
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: Definitions only
`ifndef GPF_DEFS_SVH
`define GPF_DEFS_SVH

`define GPF_ADDR_W 32
`define GPF_OFF_DBGCFG 32'h4000bc00
`define GPF_OFF_PEND 32'h4000a814
`define GPF_OFF_TRIG 32'h4000a860
`define GPF_OFF_IRQMASK 32'h4000a880
`define GPF_OFF_STATUS 32'h4000a884

`define GPF_DBGCFG_RST 32'h0000_0010
`define GPF_BIT_RSVD 3
`define GPF_BIT_REGOVR 4
`define GPF_BIT_DBGBLK 5
`define GPF_DBGCFG_WMASK 8'h30

`define GPF_TRIG_LSB 5
`define GPF_TRIG_MSB 7

`endif

// [rtl/gpf_pkg.sv]
// Purpose: Types for the pin interrupt flag bank
// Assumes: Four interrupt lines
// Notes: Constants live in gpf_defs.svh
package gpf_pkg;

    typedef enum logic [2:0] {
        TRIG_OFF = 3'h0,
        TRIG_RISE = 3'h1,
        TRIG_FALL = 3'h2,
        TRIG_BOTH = 3'h3,
        TRIG_HIGH = 3'h4,
        TRIG_LOW = 3'h5
    } gpf_trig_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } gpf_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } gpf_wb_rsp_t;

endpackage

// [rtl/gpf_regs.sv]
// Purpose: Pending flags for four pin interrupt lines plus debug pin configuration
// Assumes: Pins are asynchronous and synchronised here; one clock, 200 MHz
// Notes: Wishbone answers every access one cycle after it is seen
`include "gpf_defs.svh"

// Operation
// - line A pending flag, write one clears
// - line B pending flag, write one clears
// - line C pending flag, write one clears
// - line D pending flag, write one clears
// - bit five blocks a new debug pin takeover unless debug is active
// - bit four enables regulator override, reset on
// - flag set on configured pin trigger condition
module gpf_regs import gpf_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire gpf_wb_req_t wb_req_i,
    output gpf_wb_rsp_t wb_rsp_o,
    // Selected pins of lines A to D
    input wire logic [3:0] ext_int_pin_i,
    // Debug side
    input wire logic debug_active_i,
    input wire logic debug_request_i,
    input wire logic hw_reserved_set_i,
    input wire logic hw_reserved_clr_i,
    output logic debug_takeover_o,
    output logic regulator_override_on_o,
    // Pending flags and interrupt
    output logic [3:0] ext_interrupt_pending_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Pin synchronisers and trigger detection
    // ------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] prev_q;
    logic [3:0] event_d;
    logic [2:0] trig_q [4];
    logic [3:0] pend_q;
    logic [3:0] mask_q;
    logic [31:0] dbgcfg_q;
    logic dbg_on_q;

    // Two flops before any logic reads a pin; metastability stays here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (ce_i) begin
            sync1_q <= ext_int_pin_i;
            sync2_q <= sync1_q;
        end
    end

    // Previous settled level; only the second stage feeds it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 4'h0;
        end else if (ce_i) begin
            prev_q <= sync2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_trig
            always_comb begin
                case (gpf_trig_t'(trig_q[g]))
                    TRIG_RISE: event_d[g] = sync2_q[g] & ~prev_q[g];
                    TRIG_FALL: event_d[g] = ~sync2_q[g] & prev_q[g];
                    TRIG_BOTH: event_d[g] = sync2_q[g] ^ prev_q[g];
                    TRIG_HIGH: event_d[g] = sync2_q[g];
                    TRIG_LOW: event_d[g] = ~sync2_q[g];
                    // Off and the two spare codes never fire
                    default: event_d[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic ack_q;
    logic [31:0] rdata_d;
    logic hit_pend;
    logic hit_dbg;
    logic hit_mask;
    logic hit_stat;
    logic [3:0] hit_trig;

    assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    // Writes take effect once, in the cycle the ack is raised
    assign wr = req & wb_req_i.we;
    assign hit_pend = wb_req_i.adr == `GPF_OFF_PEND;
    assign hit_dbg = wb_req_i.adr == `GPF_OFF_DBGCFG;
    assign hit_mask = wb_req_i.adr == `GPF_OFF_IRQMASK;
    assign hit_stat = wb_req_i.adr == `GPF_OFF_STATUS;

    generate
        for (g = 0; g < 4; g++) begin : g_hit
            assign hit_trig[g] = wb_req_i.adr == `GPF_OFF_TRIG + 32'(4 * g);
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0;
        if (hit_pend) begin
            rdata_d = {28'h0, pend_q};
        end else if (hit_dbg) begin
            rdata_d = dbgcfg_q;
        end else if (hit_mask) begin
            rdata_d = {28'h0, mask_q};
        end else if (hit_stat) begin
            rdata_d = {30'h0, regulator_override_on_o, dbg_on_q};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (hit_trig[i]) begin
                    rdata_d = {24'h0, trig_q[i], 5'h0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------
    // Local copy of ack keeps a held strobe from being taken twice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req;
        end
    end

    // Unmapped addresses still ack, reading zero, so the bus never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else if (ce_i) begin
            wb_rsp_o.ack <= req;
            wb_rsp_o.dat <= req ? rdata_d : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Trigger modes and mask
    // ------------------------------------------------------------
    generate
        for (g = 0; g < 4; g++) begin : g_cfg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    trig_q[g] <= 3'h0;
                end else if (ce_i && wr && hit_trig[g] && wb_req_i.sel[0]) begin
                    trig_q[g] <= wb_req_i.dat[`GPF_TRIG_MSB:`GPF_TRIG_LSB];
                end
            end
        end
    endgenerate

    // Mask is byte lane zero only
    logic mask_wr;
    assign mask_wr = wr && hit_mask && wb_req_i.sel[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= 4'h0;
        end else if (ce_i && mask_wr) begin
            mask_q <= wb_req_i.dat[3:0];
        end
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    logic [3:0] clr;
    // Clear strobe only when byte lane zero is enabled
    logic clr_wr;
    assign clr_wr = wr && hit_pend && wb_req_i.sel[0];
    assign clr = clr_wr ? wb_req_i.dat[3:0] : 4'h0;

    generate
        for (g = 0; g < 4; g++) begin : g_pend
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pend_q[g] <= 1'b0;
                end else if (ce_i) begin
                    // Set listed after clear so a coincident event survives
                    if (clr[g]) begin
                        pend_q[g] <= 1'b0;
                    end
                    if (event_d[g]) begin
                        pend_q[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    // Unmasked pending lines; the mask never touches the flags themselves
    logic [3:0] irq_src;
    assign irq_src = pend_q & mask_q;

    // Flags leave through a flop, one cycle behind the register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_interrupt_pending_o <= 4'h0;
        end else if (ce_i) begin
            ext_interrupt_pending_o <= pend_q;
        end
    end

    // Level output, in step with the flag copy above
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |irq_src;
        end
    end

    // ------------------------------------------------------------
    // Debug pin configuration
    // ------------------------------------------------------------
    logic cfg_wr;
    assign cfg_wr = wr && hit_dbg && wb_req_i.sel[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbgcfg_q <= `GPF_DBGCFG_RST;
        end else if (ce_i) begin
            if (cfg_wr) begin
                // Software should write back bit three as read
                dbgcfg_q[7:0] <= wb_req_i.dat[7:0] & (`GPF_DBGCFG_WMASK | 8'h08);
            end
            // Hardware may move the reserved bit; hardware wins a tie
            if (hw_reserved_set_i) begin
                dbgcfg_q[`GPF_BIT_RSVD] <= 1'b1;
            end else if (hw_reserved_clr_i) begin
                dbgcfg_q[`GPF_BIT_RSVD] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Debug takeover
    // ------------------------------------------------------------
    // Block bit only bars a new takeover, never one already running
    logic dbg_grant_ok;
    assign dbg_grant_ok = !dbgcfg_q[`GPF_BIT_DBGBLK] || dbg_on_q || debug_active_i;

    // Once active, debug stays until its request drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_on_q <= 1'b0;
        end else if (ce_i) begin
            if (!debug_request_i) begin
                dbg_on_q <= 1'b0;
            end else if (dbg_grant_ok) begin
                dbg_on_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Debug outputs
    // ------------------------------------------------------------
    // Takeover reaches the pins one cycle after the grant
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_takeover_o <= 1'b0;
        end else if (ce_i) begin
            debug_takeover_o <= dbg_on_q;
        end
    end

    // Low during reset, then follows the register, which resets with it on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_override_on_o <= 1'b0;
        end else if (ce_i) begin
            regulator_override_on_o <= dbgcfg_q[`GPF_BIT_REGOVR];
        end
    end

endmodule

// [testbench/gpf_regs_checker.sv]
// Purpose: Port checks for gpf_regs
// Assumes: ce_i held high
// Notes: Bound to the register bank
`include "gpf_defs.svh"
module gpf_regs_checker import gpf_pkg::*; (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire gpf_wb_req_t wb_req_i,
    input wire gpf_wb_rsp_t wb_rsp_o,
    input wire logic [3:0] ext_int_pin_i,
    input wire logic debug_active_i,
    input wire logic debug_request_i,
    input wire logic hw_reserved_set_i,
    input wire logic hw_reserved_clr_i,
    input wire logic debug_takeover_o,
    input wire logic regulator_override_on_o,
    input wire logic [3:0] ext_interrupt_pending_o,
    input wire logic irq_o
);
    // ----
    // Bus decode
    // ----
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take, wr, rd_pend, wr_pend, wr_cfg;
    assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    assign wr = take && wb_req_i.we && wb_req_i.sel[0];
    assign rd_pend = take && !wb_req_i.we && wb_req_i.adr == `GPF_OFF_PEND;
    assign wr_pend = wr && wb_req_i.adr == `GPF_OFF_PEND;
    assign wr_cfg = wr && wb_req_i.adr == `GPF_OFF_DBGCFG;
    // ----
    // Properties
    // ----
    a_ack_one_pulse: assert property (take |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not one pulse");
    a_idle_data_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
        else $error("data without ack");
    a_pend_read_back: assert property (rd_pend |=> wb_rsp_o.dat == {28'h0, ext_interrupt_pending_o})
        else $error("pending read wrong");
    for (genvar n = 0; n < 4; n++) begin : g_flag
        a_flag_sticky: assert property ($fell(ext_interrupt_pending_o[n]) |-> $past(wr_pend && wb_req_i.dat[n], 2))
            else $error("flag lost without clear");
    end
    a_regovr_reset: assert property ($fell(rst_i) |-> ##1 regulator_override_on_o)
        else $error("override not on after reset");
    a_regovr_write: assert property (wr_cfg |=> ##1 regulator_override_on_o == $past(wb_req_i.dat[4], 2))
        else $error("override not following write");
    a_dbg_grant: assert property ((debug_request_i && debug_active_i) [*3] |-> debug_takeover_o)
        else $error("active debug refused");
    a_dbg_drop: assert property ((!debug_request_i) [*3] |-> !debug_takeover_o)
        else $error("takeover without request");
    a_irq_has_flag: assert property (irq_o |-> ext_interrupt_pending_o != 4'h0)
        else $error("irq without flag");
endmodule
bind gpf_regs gpf_regs_checker i_gpf_regs_checker (.*);

// [testbench/gpf_regs_bench.sv]
// Purpose: Self-checking bench for gpf_regs
// Assumes: ce_i high except during the final freeze check, xorshift pins from seed 92
// Notes: Pin changes wait out the synchroniser
`include "gpf_defs.svh"
module gpf_regs_bench import gpf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    gpf_wb_req_t wb_req_i = '0;
    gpf_wb_rsp_t wb_rsp_o;
    logic [3:0] ext_int_pin_i = 4'h0, ext_interrupt_pending_o;
    logic debug_active_i = 1'b0, debug_request_i = 1'b0;
    logic hw_reserved_set_i = 1'b0, hw_reserved_clr_i = 1'b0;
    logic debug_takeover_o, regulator_override_on_o, irq_o;
    int err_total = 0, checked = 0, cyc_n = 0;
    logic [31:0] seed = 32'h5c, rd;
    gpf_regs i_gpf_regs (.*);
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic fire(input int m, input logic a, input logic b);
        case (m)
            1: return !a && b;
            2: return a && !b;
            3: return a != b;
            4: return b;
            5: return !b;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        wb_req_i <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
        do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
        rd = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        int n, m;
        logic e;
        logic [3:0] p0, p1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'(regulator_override_on_o), 32'h1);
        wb(1'b0, `GPF_OFF_DBGCFG, 32'h0);
        chk(rd, `GPF_DBGCFG_RST);
        wb(1'b1, 32'h4000a800, 32'hffff_ffff);
        wb(1'b0, 32'h4000a800, 32'h0);
        chk(rd, 32'h0);
        // Every trigger mode on every line
        for (int i = 0; i < 24; i++) begin
            n = i / 6;
            m = i % 6;
            p0 = 4'(rnd());
            p1 = 4'(rnd());
            wb(1'b1, `GPF_OFF_TRIG + 32'(4 * n), 32'(m) << 5);
            wb(1'b1, `GPF_OFF_IRQMASK, 32'h1 << n);
            ext_int_pin_i <= p0;
            repeat (6) @(posedge clk_i);
            wb(1'b1, `GPF_OFF_PEND, 32'hf);
            ext_int_pin_i <= p1;
            repeat (6) @(posedge clk_i);
            e = fire(m, p0[n], p0[n]) | fire(m, p0[n], p1[n]);
            wb(1'b0, `GPF_OFF_PEND, 32'h0);
            chk(32'(rd[n]), 32'(e));
            chk(32'(irq_o), 32'(e));
            wb(1'b1, `GPF_OFF_PEND, ~(32'h1 << n));
            wb(1'b0, `GPF_OFF_PEND, 32'h0);
            chk(32'(rd[n]), 32'(e));
            wb(1'b1, `GPF_OFF_PEND, 32'h1 << n);
            wb(1'b0, `GPF_OFF_PEND, 32'h0);
            chk(32'(rd[n]), 32'(fire(m, p1[n], p1[n])));
        end
        wb(1'b0, `GPF_OFF_DBGCFG, 32'h0);
        wb(1'b1, `GPF_OFF_DBGCFG, rd & 32'h8);
        chk(32'(regulator_override_on_o), 32'h0);
        hw_reserved_set_i <= 1'b1;
        @(posedge clk_i);
        hw_reserved_set_i <= 1'b0;
        wb(1'b0, `GPF_OFF_DBGCFG, 32'h0);
        chk(rd, 32'h8);
        debug_request_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(32'(debug_takeover_o), 32'h1);
        wb(1'b1, `GPF_OFF_DBGCFG, (rd & 32'h8) | 32'h20);
        debug_request_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        debug_request_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(32'(debug_takeover_o), 32'h0);
        debug_active_i <= 1'b1;
        hw_reserved_clr_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        hw_reserved_clr_i <= 1'b0;
        chk(32'(debug_takeover_o), 32'h1);
        wb(1'b0, `GPF_OFF_DBGCFG, 32'h0);
        chk(rd, 32'h20);
        // Clock enable low freezes the flags whatever the pins do
        ce_i <= 1'b0;
        @(posedge clk_i);
        p0 = ext_interrupt_pending_o;
        ext_int_pin_i <= ~ext_int_pin_i;
        repeat (6) @(posedge clk_i);
        chk(32'(ext_interrupt_pending_o), 32'(p0));
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        wrap_up();
    end
endmodule
